// ===== icr_pkg.sv
package icr_pkg;
   localparam logic [3:0] ADDR_CONTROL_ONE   = 4'h1;
   localparam logic [3:0] ADDR_PRESCALE_LOW  = 4'h2;
   localparam logic [3:0] ADDR_PRESCALE_HIGH = 4'h3;
   localparam logic [3:0] ADDR_OWN_ADDRESS   = 4'h4;
   localparam logic [3:0] ADDR_IRQ_ENABLE    = 4'h5;
   localparam logic [3:0] ADDR_THRESHOLD     = 4'h6;
   localparam logic [3:0] ADDR_COMMAND       = 4'h7;
   localparam logic [3:0] ADDR_TX_DATA       = 4'h8;
   localparam logic [3:0] ADDR_RX_DATA       = 4'h9;
   localparam logic [3:0] ADDR_GC_DATA       = 4'hA;
   localparam logic [3:0] ADDR_STATUS        = 4'hB;
   localparam logic [3:0] ADDR_IRQ_STATUS    = 4'hC;
   localparam logic [7:0] CONTROL_ONE_RESET  = 8'h00;
   localparam logic [7:0] CONTROL_ONE_MASK   = 8'hFE;
   localparam logic [7:0] COMMAND_MASK       = 8'hFE;
   localparam logic [7:0] PRESCALE_HIGH_MASK = 8'h03;
   localparam logic [9:0] IRQ_EN_REG_MASK    = 10'h0CF;
   localparam logic [9:0] IRQ_EN_FIFO_MASK   = 10'h37F;
   localparam logic [9:0] IRQ_REG_MASK       = 10'h00F;
   localparam logic [9:0] IRQ_FIFO_MASK      = 10'h07F;
   localparam logic [6:0] GENERAL_CALL_ADDR  = 7'h00;
   // Control register one fields
   localparam int CR_CORE_ENABLE  = 7;
   localparam int CR_GC_ENABLE    = 6;
   localparam int CR_WAKE_ENABLE  = 5;
   localparam int CR_FIFO_MODE    = 4;
   localparam int CR_DELAY_HI     = 3;
   localparam int CR_DELAY_LO     = 2;
   localparam int CR_STRETCH_DIS  = 1;
   // Command fields
   localparam int CMD_START       = 7;
   localparam int CMD_STOP        = 6;
   localparam int CMD_READ        = 5;
   localparam int CMD_WRITE       = 4;
   localparam int CMD_NACK        = 3;
   localparam int CMD_STRETCH_DIS = 2;
   localparam int CMD_RBUF_DIS    = 1;
   // Interrupt enable high fields, register mode and fifo mode
   localparam int IE_REG_CLR      = 7;
   localparam int IE_REG_FRC      = 6;
   localparam int IE_FIFO_CLR     = 9;
   localparam int IE_FIFO_FRC     = 8;
   // Data line delay in ns per select code
   localparam int DELAY_NS_00     = 300;
   localparam int DELAY_NS_01     = 150;
   localparam int DELAY_NS_10     = 75;
   localparam int CLK_PERIOD_NS   = 8;
   localparam logic [7:0] DELAY_CYC_00 = 8'((DELAY_NS_00 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] DELAY_CYC_01 = 8'((DELAY_NS_01 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] DELAY_CYC_10 = 8'((DELAY_NS_10 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] DELAY_CYC_11 = 8'h00;
   localparam logic [11:0] PRESCALE_FACTOR = 12'h004;
   localparam logic [3:0]  BIT_COUNT_LAST  = 4'h8;
   typedef enum logic [3:0] {
      ICR_IDLE, ICR_START, ICR_BIT_LOW, ICR_BIT_HIGH, ICR_ACK_LOW, ICR_ACK_HIGH,
      ICR_STOP_LOW, ICR_STOP_HIGH
   } icr_state_e;
endpackage : icr_pkg

// ===== icr_core.sv
`timescale 1ns/10ps
// How it works
// R1: twelve registers at sub-addresses one through twelve
// R2: any control-one write resets the core
// R3: enable cleared forces core idle
// R4: general call answered when enabled
// R5: own address match raises wake in standby
// R6: queue mode bit selects register or fifo
// R7: delay select sets data line output delay
// R8: stretch disable applies in fifo mode
// R9: command bits start, stop, read, write
// R10: command bit three chooses ack or nack
// R11: command bit two disables clock stretching
// R12: command bit one disables read buffer
// R13: scl is bus clock over four times prescale
// R14: write to high prescale resets core
// R15: status meaning follows selected mode
// R16: transfer flag high during byte transfer
// R17: busy set at start, cleared at stop
// R18: ack received flag reflects acknowledge
// R19: direction flag shows transfer direction
// R20: arbitration lost flag raises interrupt
// R21: ready flag shows data register readiness
// R22: error flag is nack or overrun
// R23: fifo nack sets flag, stops, idles
// R24: read done flag set when a read byte is sent with command bit three (nack) set
// R25: status bits set when enabled, write-one clears
// R26: auto clear on read, force bit, register mode only (fifo mode bits 9 and 8 cannot be written)
// R27: data sent most significant bit first
// R28: enabled status bits combine to interrupt
// R29: read-only writes ignored, reserved read zero
module icr_core
   import icr_pkg::*;
#(
   parameter logic [9:0] OWN_ADDR_RESET = 10'h000
)(
   // System
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   // System bus
   input  wire logic             i_sb_stb,
   input  wire logic             i_sb_we,
   input  wire logic [3:0]       i_sb_addr,
   input  wire logic [7:0]       i_sb_wdata,
   output logic      [7:0]       o_sb_rdata,
   output logic                  o_sb_ack,
   // Bus pins
   input  wire logic             i_scl,
   output logic                  o_scl,
   output logic                  o_scl_oe,
   input  wire logic             i_sda,
   output logic                  o_sda,
   output logic                  o_sda_oe,
   // Power and interrupt
   input  wire logic             i_standby,
   output logic                  o_wake,
   output logic                  o_irq
);
   import icr_pkg::*;

   logic [7:0]  control_one, next_control_one;
   logic [7:0]  prescale_low, next_prescale_low;
   logic [7:0]  prescale_high, next_prescale_high;
   logic [9:0]  own_addr, next_own_addr;
   logic [9:0]  irq_enable, next_irq_enable;
   logic [9:0]  threshold, next_threshold;
   logic [7:0]  command, next_command;
   logic [7:0]  tx_data, next_tx_data;
   logic [7:0]  rx_data, next_rx_data;
   logic [7:0]  gc_data;
   logic [9:0]  irq_status, next_irq_status;
   logic [7:0]  rdata, next_rdata;
   logic        ack, next_ack;
   logic        core_reset, next_core_reset;
   // Protocol engine state
   icr_state_e  state, next_state;
   logic [11:0] tick_cnt, next_tick_cnt;
   logic [3:0]  bit_cnt, next_bit_cnt;
   logic [7:0]  shift, next_shift;
   logic [7:0]  dly_cnt, next_dly_cnt;
   logic        sda_want, next_sda_want;
   logic        sda_out, next_sda_out;
   logic        scl_out, next_scl_out;
   logic        busy, next_busy;
   logic        transfer_in_progress, next_tip;
   logic        ack_rx, next_ack_rx;
   logic        dir, next_dir;
   logic        arb_lost, next_arb_lost;
   logic        ready, next_ready;
   logic        err, next_err;
   logic        nack_seen, next_nack_seen;
   logic        read_done, next_read_done;
   logic        gc_seen, next_gc_seen;
   logic        wake, next_wake;
   logic        irq, next_irq;
   logic        scl_q, sda_q;

   function automatic logic [9:0] status_word(input logic fifo);
      if (fifo)
         status_word = {3'h0, gc_seen, nack_seen, read_done, arb_lost, 3'h0}; // R15
      else
         status_word = {2'h0, transfer_in_progress, busy, ack_rx, dir, arb_lost, ready, err, gc_seen};
   endfunction : status_word

   wire         fifo_mode  = control_one[CR_FIFO_MODE]; // R6
   wire         wr         = i_sb_stb & i_sb_we & ~ack;
   wire         rd         = i_sb_stb & ~i_sb_we & ~ack;
   wire  [9:0]  prescale   = {prescale_high[1:0], prescale_low};
   wire  [11:0] half_tick  = 12'({2'h0, prescale} * PRESCALE_FACTOR) >> 1; // R13
   wire         tick       = (tick_cnt >= 12'(half_tick - 12'h001)) && (prescale != 10'h000);
   logic [9:0]  st_word;
   // Process form so the flags read inside the function wake it up
   always_comb st_word = status_word(fifo_mode); // R15
   wire         stretch_off = fifo_mode ? control_one[CR_STRETCH_DIS] // R8
                                        : command[CMD_STRETCH_DIS]; // R11
   wire  [9:0]  src_flags  = fifo_mode ? {3'h0, gc_seen, nack_seen, read_done, arb_lost, 3'h0}
                                       : {6'h0, arb_lost, ready, err, gc_seen};
   wire  [9:0]  en_mask    = fifo_mode ? IRQ_FIFO_MASK : IRQ_REG_MASK;
   wire         auto_clr   = fifo_mode ? irq_enable[IE_FIFO_CLR] : irq_enable[IE_REG_CLR];
   wire         force_irq  = fifo_mode ? irq_enable[IE_FIFO_FRC] : irq_enable[IE_REG_FRC];
   wire  [7:0]  dly_load   = (control_one[CR_DELAY_HI:CR_DELAY_LO] == 2'b00) ? DELAY_CYC_00 // R7
                           : (control_one[CR_DELAY_HI:CR_DELAY_LO] == 2'b01) ? DELAY_CYC_01
                           : (control_one[CR_DELAY_HI:CR_DELAY_LO] == 2'b10) ? DELAY_CYC_10
                           : DELAY_CYC_11;

   // Register file and bus slave
   always_comb
   begin
      next_control_one   = control_one;
      next_prescale_low  = prescale_low;
      next_prescale_high = prescale_high;
      next_own_addr      = own_addr;
      next_irq_enable    = irq_enable;
      next_threshold     = threshold;
      next_tx_data       = tx_data;
      next_rdata         = rdata;
      next_core_reset    = 1'b0;
      next_ack           = i_sb_stb & ~ack;
      if (wr)
      begin
         if (i_sb_addr == ADDR_CONTROL_ONE)
         begin
            next_control_one = i_sb_wdata & CONTROL_ONE_MASK;
            next_core_reset  = 1'b1; // R2
         end
         else if (i_sb_addr == ADDR_PRESCALE_LOW)
            next_prescale_low = i_sb_wdata;
         else if (i_sb_addr == ADDR_PRESCALE_HIGH)
         begin
            next_prescale_high = i_sb_wdata & PRESCALE_HIGH_MASK;
            next_core_reset    = 1'b1; // R14
         end
         else if (i_sb_addr == ADDR_OWN_ADDRESS)
            next_own_addr = {2'h0, i_sb_wdata};
         else if (i_sb_addr == ADDR_IRQ_ENABLE)
            next_irq_enable = {2'h0, i_sb_wdata} & (fifo_mode ? IRQ_EN_FIFO_MASK
                                                              : IRQ_EN_REG_MASK);
         else if (i_sb_addr == ADDR_THRESHOLD)
            next_threshold = {2'h0, i_sb_wdata};
         else if (i_sb_addr == ADDR_TX_DATA)
            next_tx_data = i_sb_wdata;
         // Status, receive and general call stay untouched
         // R29
      end
      if (rd)
      begin
         if (i_sb_addr == ADDR_CONTROL_ONE)
            next_rdata = control_one;
         else if (i_sb_addr == ADDR_PRESCALE_LOW)
            next_rdata = prescale_low;
         else if (i_sb_addr == ADDR_PRESCALE_HIGH)
            next_rdata = prescale_high;
         else if (i_sb_addr == ADDR_OWN_ADDRESS)
            next_rdata = own_addr[7:0];
         else if (i_sb_addr == ADDR_IRQ_ENABLE)
            next_rdata = irq_enable[7:0];
         else if (i_sb_addr == ADDR_THRESHOLD)
            next_rdata = threshold[7:0];
         else if (i_sb_addr == ADDR_COMMAND)
            next_rdata = command;
         else if (i_sb_addr == ADDR_RX_DATA)
            next_rdata = rx_data;
         else if (i_sb_addr == ADDR_GC_DATA)
            next_rdata = gc_data;
         else if (i_sb_addr == ADDR_STATUS)
            next_rdata = st_word[7:0]; // R1
         else if (i_sb_addr == ADDR_IRQ_STATUS)
            next_rdata = irq_status[7:0];
         else
            next_rdata = 8'h00; // R29
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         control_one   <= CONTROL_ONE_RESET;
         prescale_low  <= 8'h00;
         prescale_high <= 8'h00;
         own_addr      <= OWN_ADDR_RESET;
         irq_enable    <= 10'h000;
         threshold     <= 10'h000;
         tx_data       <= 8'h00;
         rdata         <= 8'h00;
         ack           <= 1'b0;
         core_reset    <= 1'b0;
      end
      else
      begin
         control_one   <= next_control_one;
         prescale_low  <= next_prescale_low;
         prescale_high <= next_prescale_high;
         own_addr      <= next_own_addr;
         irq_enable    <= next_irq_enable;
         threshold     <= next_threshold;
         tx_data       <= next_tx_data;
         rdata         <= next_rdata;
         ack           <= next_ack;
         core_reset    <= next_core_reset;
      end
   end

   // Interrupt status, set wins over clear
   always_comb
   begin
      next_irq_status = irq_status;
      if (wr && i_sb_addr == ADDR_IRQ_STATUS)
         next_irq_status = irq_status & ~{2'h0, i_sb_wdata}; // R25
      if (rd && i_sb_addr == ADDR_IRQ_STATUS && auto_clr)
         next_irq_status = 10'h000; // R26
      next_irq_status = (next_irq_status | (src_flags & irq_enable)) & en_mask; // R25
      next_irq = (|next_irq_status) | force_irq; // R28 R26 R20
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         irq_status <= 10'h000;
         irq        <= 1'b0;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq        <= next_irq;
      end
   end

   // Protocol engine
   always_comb
   begin
      next_state     = state;
      next_command   = command;
      next_tick_cnt  = tick ? 12'h000 : 12'(tick_cnt + 12'h001);
      next_bit_cnt   = bit_cnt;
      next_shift     = shift;
      next_sda_want  = sda_want;
      next_scl_out   = scl_out;
      next_busy      = busy;
      next_tip       = transfer_in_progress;
      next_ack_rx    = ack_rx;
      next_dir       = dir;
      next_arb_lost  = arb_lost;
      next_ready     = ready;
      next_err       = err;
      next_nack_seen = nack_seen;
      next_read_done = read_done;
      next_gc_seen   = gc_seen;
      next_rx_data   = rx_data;
      next_wake      = i_standby & control_one[CR_WAKE_ENABLE] & wake;
      if (wr && i_sb_addr == ADDR_COMMAND)
         next_command = i_sb_wdata & COMMAND_MASK;
      if (wr && i_sb_addr == ADDR_TX_DATA)
         next_ready = 1'b0;
      if (rd && i_sb_addr == ADDR_RX_DATA)
         next_ready = 1'b0;
      // Busy from start and stop seen on the bus
      if (scl_q && i_scl && sda_q && !i_sda)
         next_busy = 1'b1; // R17
      if (scl_q && i_scl && !sda_q && i_sda)
         next_busy = 1'b0; // R17
      case (state)
         ICR_IDLE:
         begin
            next_scl_out  = 1'b1;
            next_sda_want = 1'b1;
            next_tip      = 1'b0;
            if (command[CMD_START] && tick)
            begin
               next_sda_want = 1'b0; // R9
               next_state    = ICR_START;
               next_shift    = tx_data;
               next_dir      = tx_data[0];
               next_arb_lost = 1'b0;
            end
            else if ((command[CMD_WRITE] || command[CMD_READ]) && tick)
            begin
               next_shift = command[CMD_READ] ? 8'hFF : tx_data; // R9
               next_dir   = command[CMD_READ]; // R19
               next_state = ICR_BIT_LOW;
               next_scl_out = 1'b0;
               next_bit_cnt = 4'h0;
               next_tip   = 1'b1;
               next_sda_want = command[CMD_READ] ? 1'b1 : tx_data[7]; // R27
               next_command[CMD_WRITE] = 1'b0;
               next_command[CMD_READ]  = command[CMD_RBUF_DIS] ? 1'b0 : command[CMD_READ]; // R12
            end
            else if (command[CMD_STOP] && tick)
            begin
               next_sda_want = 1'b0;
               next_state    = ICR_STOP_LOW;
            end
         end
         ICR_START:
            if (tick)
            begin
               next_scl_out = 1'b0;
               next_bit_cnt = 4'h0;
               next_tip     = 1'b1; // R16
               next_sda_want = shift[7]; // R27
               next_command[CMD_START] = 1'b0;
               next_command[CMD_WRITE] = 1'b0;
               next_state   = ICR_BIT_LOW;
            end
         ICR_BIT_LOW:
            if (tick)
            begin
               next_scl_out  = 1'b1;
               next_state    = ICR_BIT_HIGH;
            end
         ICR_BIT_HIGH:
            if (tick && (i_scl || stretch_off))
            begin
               if (shift[7] && !i_sda && !dir)
               begin
                  next_arb_lost = 1'b1; // R20
                  next_state    = ICR_IDLE;
               end
               else
               begin
                  next_shift   = {shift[6:0], i_sda};
                  // Data changes only while the clock is low
                  next_sda_want = shift[6]; // R27
                  if (4'(bit_cnt + 4'h1) == BIT_COUNT_LAST)
                     next_sda_want = dir ? command[CMD_NACK] : 1'b1; // R10
                  next_bit_cnt = 4'(bit_cnt + 4'h1);
                  next_scl_out = 1'b0;
                  next_state   = (4'(bit_cnt + 4'h1) == BIT_COUNT_LAST) ? ICR_ACK_LOW
                                                                      : ICR_BIT_LOW;
               end
            end
         ICR_ACK_LOW:
            if (tick)
            begin
               next_scl_out  = 1'b1;
               next_state    = ICR_ACK_HIGH;
            end
         ICR_ACK_HIGH:
            if (tick)
            begin
               next_scl_out = 1'b0;
               next_tip     = 1'b0;
               next_ready   = 1'b1; // R21
               if (dir)
               begin
                  if (ready)
                     next_err = 1'b1; // R22
                  next_rx_data = shift;
                  next_ack_rx  = ~command[CMD_NACK]; // R18
                  next_read_done = command[CMD_NACK]; // R24
                  next_state   = ICR_IDLE;
               end
               else
               begin
                  next_ack_rx = ~i_sda; // R18
                  next_err    = i_sda; // R22
                  if (shift == {GENERAL_CALL_ADDR, 1'b0} && control_one[CR_GC_ENABLE])
                     next_gc_seen = 1'b1; // R4
                  if (i_standby && control_one[CR_WAKE_ENABLE] && shift[7:1] == own_addr[6:0])
                     next_wake = 1'b1; // R5
                  if (i_sda && fifo_mode)
                  begin
                     next_nack_seen = 1'b1; // R23
                     next_sda_want  = 1'b0;
                     next_state     = ICR_STOP_LOW;
                  end
                  else
                     next_state = ICR_IDLE;
               end
            end
         ICR_STOP_LOW:
            if (tick)
            begin
               next_scl_out = 1'b1;
               next_state   = ICR_STOP_HIGH;
            end
         default:
            if (tick)
            begin
               next_sda_want = 1'b1;
               next_command[CMD_STOP] = 1'b0;
               next_state = ICR_IDLE; // R23
            end
      endcase
      if (!control_one[CR_CORE_ENABLE] || core_reset)
      begin
         next_state    = ICR_IDLE; // R3 R2 R14
         next_scl_out  = 1'b1;
         next_sda_want = 1'b1;
         next_tip      = 1'b0;
         next_busy     = 1'b0;
      end
   end

   // Output delay on the data line
   always_comb
   begin
      next_dly_cnt = dly_cnt;
      next_sda_out = sda_out;
      if (sda_want == sda_out)
         next_dly_cnt = dly_load;
      else if (dly_cnt == 8'h00)
         next_sda_out = sda_want; // R7
      else
         next_dly_cnt = 8'(dly_cnt - 8'h01);
      if (!control_one[CR_CORE_ENABLE] || core_reset)
         next_sda_out = 1'b1; // R3
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state     <= ICR_IDLE;
         command   <= 8'h00;
         tick_cnt  <= 12'h000;
         bit_cnt   <= 4'h0;
         shift     <= 8'h00;
         dly_cnt   <= 8'h00;
         sda_want  <= 1'b1;
         sda_out   <= 1'b1;
         scl_out   <= 1'b1;
         busy      <= 1'b0;
         transfer_in_progress       <= 1'b0;
         ack_rx    <= 1'b0;
         dir       <= 1'b0;
         arb_lost  <= 1'b0;
         ready     <= 1'b0;
         err       <= 1'b0;
         nack_seen <= 1'b0;
         read_done <= 1'b0;
         gc_seen   <= 1'b0;
         rx_data   <= 8'h00;
         wake      <= 1'b0;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
      end
      else
      begin
         state     <= next_state;
         command   <= next_command;
         tick_cnt  <= next_tick_cnt;
         bit_cnt   <= next_bit_cnt;
         shift     <= next_shift;
         dly_cnt   <= next_dly_cnt;
         sda_want  <= next_sda_want;
         sda_out   <= next_sda_out;
         scl_out   <= next_scl_out;
         busy      <= next_busy;
         transfer_in_progress       <= next_tip;
         ack_rx    <= next_ack_rx;
         dir       <= next_dir;
         arb_lost  <= next_arb_lost;
         ready     <= next_ready;
         err       <= next_err;
         nack_seen <= next_nack_seen;
         read_done <= next_read_done;
         gc_seen   <= next_gc_seen;
         rx_data   <= next_rx_data;
         wake      <= next_wake;
         scl_q     <= i_scl;
         sda_q     <= i_sda;
      end
   end

   assign gc_data    = 8'h00;
   assign o_sb_rdata = rdata;
   assign o_sb_ack   = ack;
   assign o_scl      = 1'b0;
   assign o_scl_oe   = ~scl_out;
   assign o_sda      = 1'b0;
   assign o_sda_oe   = ~sda_out;
   assign o_wake     = wake;
   assign o_irq      = irq;
endmodule : icr_core

// ===== icr_core_sva.sv
`timescale 1ns/10ps
module icr_core_sva
   import icr_pkg::*;
(
   // System
   input wire logic       i_clk,
   input wire logic       i_reset_n,
   // System bus
   input wire logic       i_sb_stb,
   input wire logic       i_sb_we,
   input wire logic [3:0] i_sb_addr,
   input wire logic [7:0] i_sb_wdata,
   input wire logic [7:0] o_sb_rdata,
   input wire logic       o_sb_ack,
   // Pins
   input wire logic       o_scl_oe,
   input wire logic       o_sda_oe,
   input wire logic       i_standby,
   input wire logic       o_wake
);
   logic take;
   assign take = i_sb_stb && !o_sb_ack;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_ack_after_take: assert property (take |=> o_sb_ack)
      else $error("ack missing after request");
   a_ack_one_cycle: assert property (o_sb_ack |=> !o_sb_ack)
      else $error("ack longer than one cycle");
   a_ack_has_cause: assert property (o_sb_ack |-> $past(take))
      else $error("ack without request");
   a_unmapped_zero: assert property (take && !i_sb_we && (i_sb_addr == 4'h0
      || i_sb_addr > ADDR_IRQ_STATUS) |=> o_sb_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_reserved_zero: assert property (take && !i_sb_we && (i_sb_addr == ADDR_CONTROL_ONE
      || i_sb_addr == ADDR_COMMAND) |=> !o_sb_rdata[0])
      else $error("reserved bit not zero");
   a_rdata_on_read: assert property ($changed(o_sb_rdata) |-> $past(take && !i_sb_we))
      else $error("read data moved without read");
   a_disable_idle: assert property (take && i_sb_we && i_sb_addr == ADDR_CONTROL_ONE
      && !i_sb_wdata[CR_CORE_ENABLE] |-> ##3 (!o_scl_oe && !o_sda_oe)[*4])
      else $error("bus driven while disabled");
   a_wake_standby: assert property (o_wake |-> $past(i_standby))
      else $error("wake outside standby");
endmodule : icr_core_sva
bind icr_core icr_core_sva chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sb_stb(i_sb_stb),
   .i_sb_we(i_sb_we), .i_sb_addr(i_sb_addr), .i_sb_wdata(i_sb_wdata),
   .o_sb_rdata(o_sb_rdata), .o_sb_ack(o_sb_ack), .o_scl_oe(o_scl_oe),
   .o_sda_oe(o_sda_oe), .i_standby(i_standby), .o_wake(o_wake));

// ===== icr_bus_model.sv
`timescale 1ns/10ps
module icr_bus_model (
   input  wire logic       i_scl_oe,
   input  wire logic       i_sda_oe,
   input  wire logic       i_ack_en,
   output logic            o_scl,
   output logic            o_sda,
   output logic [7:0]      o_byte,
   output logic [3:0]      o_bits
);
   logic ack_pull = 1'b0;
   // Pull-ups on both lines
   assign o_scl = !i_scl_oe;
   assign o_sda = !(i_sda_oe || ack_pull);
   initial o_bits = 4'h0;
   always @(negedge o_sda)
      if (o_scl) o_bits = 4'h0;
   always @(posedge o_scl)
      if (o_bits < 4'h8)
      begin
         o_byte = {o_byte[6:0], o_sda};
         o_bits = o_bits + 4'h1;
      end
   always @(negedge o_scl)
      if (ack_pull)
      begin
         ack_pull = 1'b0;
         o_bits   = 4'h9;
      end
      else if (o_bits == 4'h8) ack_pull = i_ack_en;
endmodule : icr_bus_model

// ===== i2c_core_register_control_tb_top.sv
`timescale 1ns/10ps
module i2c_core_register_control_tb_top;
   import icr_pkg::*;
   logic       clk, rst_n, stb, we, stby, ack, scl_oe, sda_oe, wake, irq, scl, sda;
   logic [3:0] addr, mbits;
   logic [7:0] wd, rd, q, mbyte;
   int         num_errors, checked, n;
   icr_core uut (.i_clk(clk), .i_reset_n(rst_n), .i_sb_stb(stb), .i_sb_we(we),
      .i_sb_addr(addr), .i_sb_wdata(wd), .o_sb_rdata(rd), .o_sb_ack(ack), .i_scl(scl),
      .o_scl(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe),
      .i_standby(stby), .o_wake(wake), .o_irq(irq));
   icr_bus_model partner (.i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .i_ack_en(1'b1),
      .o_scl(scl), .o_sda(sda), .o_byte(mbyte), .o_bits(mbits));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      int k;
      @(negedge clk);
      stb  = 1'b1;
      we   = w;
      addr = a;
      wd   = d;
      k    = 0;
      do
      begin
         @(negedge clk);
         k++;
      end while (ack !== 1'b1 && k < 8);
      q = rd;
      chk("ack", 8'h01, {7'h00, ack});
      @(negedge clk);
      stb = 1'b0;
   endtask : acc
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk($sformatf("register %h", a), e, q);
   endtask : rdchk
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   initial
   begin
      #100000;
      num_errors++;
      conclude();
   end
   initial
   begin
      {rst_n, stb, we, stby, addr, wd} = '0;
      repeat (4) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      rdchk(ADDR_CONTROL_ONE, CONTROL_ONE_RESET);
      rdchk(ADDR_PRESCALE_LOW, 8'h00);
      rdchk(ADDR_PRESCALE_HIGH, 8'h00);
      rdchk(ADDR_COMMAND, 8'h00);
      for (int a = 13; a < 17; a++) rdchk(4'(a), 8'h00);
      $display("test reset values done");
      acc(1'b1, ADDR_CONTROL_ONE, 8'hFF);
      rdchk(ADDR_CONTROL_ONE, 8'hFE);
      acc(1'b1, ADDR_CONTROL_ONE, 8'h00);
      acc(1'b1, ADDR_PRESCALE_HIGH, 8'hFF);
      rdchk(ADDR_PRESCALE_HIGH, PRESCALE_HIGH_MASK);
      acc(1'b1, ADDR_COMMAND, 8'h0F);
      rdchk(ADDR_COMMAND, 8'h0E);
      acc(1'b1, ADDR_GC_DATA, 8'hFF);
      rdchk(ADDR_GC_DATA, 8'h00);
      acc(1'b1, ADDR_IRQ_ENABLE, 8'hFF);
      rdchk(ADDR_IRQ_ENABLE, IRQ_EN_REG_MASK[7:0]);
      chk("irq forced", 8'h01, {7'h00, irq});
      acc(1'b1, ADDR_IRQ_ENABLE, 8'h00);
      repeat (2) @(negedge clk);
      chk("irq", 8'h00, {7'h00, irq});
      stby = 1'b1;
      repeat (3) @(negedge clk);
      chk("wake", 8'h00, {7'h00, wake});
      stby = 1'b0;
      $display("test register access done");
      // Half clock period must exceed the data line delay
      acc(1'b1, ADDR_PRESCALE_LOW, 8'h20);
      acc(1'b1, ADDR_PRESCALE_HIGH, 8'h00);
      acc(1'b1, ADDR_CONTROL_ONE, 8'h80);
      acc(1'b1, ADDR_TX_DATA, 8'hA4);
      acc(1'b1, ADDR_COMMAND, 8'h90);
      for (n = 0; n < 3000 && mbits !== 4'h8; n++) @(negedge clk);
      chk("byte on wire", 8'hA4, mbyte);
      acc(1'b0, ADDR_STATUS, 8'h00);
      chk("busy and direction", 8'h40, q & 8'h50);
      for (n = 0; n < 2000 && mbits !== 4'h9; n++) @(negedge clk);
      acc(1'b1, ADDR_COMMAND, 8'h40);
      for (n = 0; n < 200 && q[6] !== 1'b0; n++) acc(1'b0, ADDR_STATUS, 8'h00);
      chk("busy after stop", 8'h00, {7'h00, q[6]});
      chk("ack and error", 8'h20, q & 8'h22);
      $display("test transfer done");
      acc(1'b1, ADDR_CONTROL_ONE, 8'h00);
      repeat (6) @(negedge clk);
      chk("line drive", 8'h00, {6'h00, scl_oe, sda_oe});
      $display("test disable done");
      conclude();
   end
endmodule : i2c_core_register_control_tb_top
